// *** pkg/blsl_defines.svh ***
`ifndef BLSL_DEFINES_SVH
`define BLSL_DEFINES_SVH
`define BLSL_CLK_NS 5
`define BLSL_TICK_US 1000
`define BLSL_TICK_CYC ((`BLSL_TICK_US * 1000) / `BLSL_CLK_NS)
`define BLSL_DRL_QUAL_S 2
`define BLSL_FADE_S 2
`define BLSL_DOOR_MIN 10
`define BLSL_UNLOCK_MIN 1
`define BLSL_CLOSE_S 15
`define BLSL_DRL_TICKS (20'(`BLSL_DRL_QUAL_S * 1000 + 1))
`define BLSL_FADE_TICKS (20'(`BLSL_FADE_S * 1000))
`define BLSL_DOOR_TICKS (20'(`BLSL_DOOR_MIN * 60000))
`define BLSL_UNLOCK_TICKS (20'(`BLSL_UNLOCK_MIN * 60000))
`define BLSL_CLOSE_TICKS (20'(`BLSL_CLOSE_S * 1000))
`define BLSL_ODO_MAX 21'h188D27
`define BLSL_ODO_TOL 21'h00000A
`define BLSL_SAME_LAST 4'hE
`define BLSL_REG_CTRL 8'h00
`define BLSL_REG_STATUS 8'h04
`define BLSL_REG_ODO 8'h08
`define BLSL_CTRL_RESET 32'h00000000
`define BLSL_CTRL_DRL 1:0
`define BLSL_CTRL_FFOG 3:2
`define BLSL_CTRL_WARN 4
`define BLSL_CTRL_AUTO 5
`define BLSL_CTRL_TRANSIT 6
`define BLSL_ODO_RESET 21'h000000
`endif

// *** pkg/blsl_pkg.sv ***
package blsl_pkg;
  typedef enum logic [1:0] {
    BLSL_IGN_OFF = 2'b00,
    BLSL_IGN_AUX = 2'b01,
    BLSL_IGN_RUN = 2'b10,
    BLSL_IGN_CRANK = 2'b11
  } blsl_ign_t;
  typedef enum logic [2:0] {
    BLSL_GEAR_P = 3'b000,
    BLSL_GEAR_R = 3'b001,
    BLSL_GEAR_N = 3'b010,
    BLSL_GEAR_D = 3'b011
  } blsl_gear_t;
  typedef enum logic [1:0] {
    BLSL_DRL_NONE = 2'b00,
    BLSL_DRL_NO_MAIN = 2'b01,
    BLSL_DRL_NO_BEAM_PARK = 2'b10
  } blsl_drl_t;
  typedef enum logic [1:0] {
    BLSL_FOG_NONE = 2'b00,
    BLSL_FOG_MAIN_IGNORED = 2'b01,
    BLSL_FOG_OFF_MAIN = 2'b10
  } blsl_fog_t;
  typedef enum logic [1:0] {
    BLSL_WR_IDLE = 2'b00,
    BLSL_WR_RESP = 2'b01
  } blsl_wr_t;
endpackage

// *** verilog/blsl_tmr.sv ***
`timescale 1ns/1ps
module blsl_tmr (
  // Clocking
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic tick,
  // Control
  input wire logic start,
  input wire logic cancel,
  input wire logic [19:0] load,
  // State
  output logic busy,
  output logic done,
  output logic [19:0] remain
);
  assign busy = remain != 20'h00000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      remain <= 20'h00000;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (cancel)
        remain <= 20'h00000;
      else if (start)
        remain <= load;
      else if (tick && busy)
      begin
        remain <= remain - 20'h00001;
        done <= remain == 20'h00001;
      end
    end
  end
endmodule

// *** verilog/blsl_top.sv ***
// What this block does
// - Daylight lamps: absent, on with main off, or on with beams off and not Park.
// - Daylight relay needs engine running held at least two seconds.
// - Front fog only with lights on; drops with lights or ignition, needs new press.
// - Front fog switching off also switches rear fog off, except on link failure or with front fog absent.
// - Crank saves and blanks front fog, ignores presses, restores after, ignition off clears.
// - Front fog mode: absent, main ignored, or suspended during main beam.
// - Link failure switches an active front fog relay off.
// - Rear fog only with lights on; drops with lights or ignition, needs new press.
// - Crank saves and blanks rear fog, ignores presses, restores after, ignition off clears.
// - Link failure leaves rear fog on until ignition or lights go off.
// - Courtesy lamps start full and fade out over two seconds after the hold.
// - An opening door holds courtesy lamps up to ten minutes.
// - Unlock with doors shut outside crank, or ignition to off, holds one minute.
// - Last door closing outside crank holds courtesy lamps fifteen seconds.
// - Crank or a lock command cancels the courtesy hold.
// - Transit mode makes every courtesy hold fifteen seconds.
// - Odometer check only with ignition on; readings clamp to the maximum.
// - Sixteen identical readings compare; stored value catches up when up to 10 behind.
// - Warning option flags a reading 10 or more away from the stored value.
// - Starter enabled in crank only when immobiliser released and engine not running.
// - Link failure forces engine running false.
// - Cruise inhibit on with ignition and brake, or automatic in N, P or R.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "blsl_defines.svh"
module blsl_top #(
  parameter int TICK_CYCLES = `BLSL_TICK_CYC
) (
  // Clocking
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Vehicle inputs
  input wire logic [1:0] ign_pos,
  input wire logic side_on,
  input wire logic dip_on,
  input wire logic main_on,
  input wire logic ff_btn,
  input wire logic rf_btn,
  input wire logic eng_run,
  input wire logic link_fail,
  input wire logic immob_ok,
  input wire logic brake,
  input wire logic [2:0] gear,
  input wire logic [3:0] doors,
  input wire logic remote_unlock,
  input wire logic drv_unlock,
  input wire logic lock_cmd,
  input wire logic [20:0] odo_rx,
  input wire logic odo_rx_valid,
  // Relay and link outputs
  output logic drl_rly,
  output logic ff_rly,
  output logic rf_rly,
  output logic courtesy_lamp,
  output logic starter_rly,
  output logic nrpb_out,
  output logic odo_flash
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        merge[i*8 +: 8] = nw[i*8 +: 8];
  endfunction

  function automatic logic [20:0] absdiff(input logic [20:0] a, input logic [20:0] b);
    absdiff = (a >= b) ? a - b : b - a;
  endfunction

  // Register bus
  logic [31:0] ctrl;
  logic [20:0] odo_store;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  blsl_pkg::blsl_wr_t wr_state;
  logic [31:0] status;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_go;
  logic wr_hit;
  logic [31:0] next_ctrl;
  logic [20:0] next_odo_sw;
  logic [31:0] odo_sw_word;

  assign s_axi_awready = !aw_held && wr_state == blsl_pkg::BLSL_WR_IDLE;
  assign s_axi_wready = !w_held && wr_state == blsl_pkg::BLSL_WR_IDLE;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bvalid = wr_state == blsl_pkg::BLSL_WR_RESP;
  assign wr_go = aw_held && w_held && wr_state == blsl_pkg::BLSL_WR_IDLE;
  assign wr_hit = aw_addr == `BLSL_REG_CTRL || aw_addr == `BLSL_REG_ODO;
  assign next_ctrl = merge(ctrl, w_data, w_strb);
  assign odo_sw_word = merge({11'h000, odo_store}, w_data, w_strb);
  assign next_odo_sw = odo_sw_word[20:0];
  assign rd_hit = s_axi_araddr == `BLSL_REG_CTRL || s_axi_araddr == `BLSL_REG_STATUS
    || s_axi_araddr == `BLSL_REG_ODO;
  assign rd_word = s_axi_araddr == `BLSL_REG_CTRL ? ctrl
    : s_axi_araddr == `BLSL_REG_STATUS ? status
    : s_axi_araddr == `BLSL_REG_ODO ? {11'h000, odo_store} : 32'h00000000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      wr_state <= blsl_pkg::BLSL_WR_IDLE;
      s_axi_bresp <= 2'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      case (wr_state)
        blsl_pkg::BLSL_WR_IDLE:
          if (wr_go)
          begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
            wr_state <= blsl_pkg::BLSL_WR_RESP;
          end
        blsl_pkg::BLSL_WR_RESP:
          if (s_axi_bready)
            wr_state <= blsl_pkg::BLSL_WR_IDLE;
        default:
          wr_state <= blsl_pkg::BLSL_WR_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Decoded inputs and configuration
  logic [17:0] tick_cnt;
  logic tick;
  logic crank;
  logic ign_on;
  logic lights;
  logic eng_eff;
  logic auto_gbox;
  logic transit;
  logic [1:0] drl_mode;
  logic [1:0] ff_mode;
  assign tick = tick_cnt == 18'(TICK_CYCLES - 1);
  assign crank = ign_pos == blsl_pkg::BLSL_IGN_CRANK;
  assign ign_on = ign_pos[1];
  assign lights = side_on || dip_on || main_on;
  assign eng_eff = eng_run && !link_fail;
  assign drl_mode = ctrl[`BLSL_CTRL_DRL];
  assign ff_mode = ctrl[`BLSL_CTRL_FFOG];
  assign auto_gbox = ctrl[`BLSL_CTRL_AUTO];
  assign transit = ctrl[`BLSL_CTRL_TRANSIT];

  // Edge memories
  logic eng_prev;
  logic ff_btn_prev;
  logic rf_btn_prev;
  logic [1:0] ign_prev;
  logic [3:0] doors_prev;
  logic hold_prev;
  logic ff_prev;
  logic ff_on;
  logic hold_busy;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt <= 18'h00000;
      eng_prev <= 1'b0;
      ff_btn_prev <= 1'b0;
      rf_btn_prev <= 1'b0;
      ign_prev <= 2'h0;
      doors_prev <= 4'h0;
      hold_prev <= 1'b0;
      ff_prev <= 1'b0;
    end
    else if (ce)
    begin
      tick_cnt <= tick ? 18'h00000 : tick_cnt + 18'h00001;
      eng_prev <= eng_eff;
      ff_btn_prev <= ff_btn;
      rf_btn_prev <= rf_btn;
      ign_prev <= ign_pos;
      doors_prev <= doors;
      hold_prev <= hold_busy;
      ff_prev <= ff_on;
    end
  end

  // Daylight lamps
  logic drl_done;
  logic eng_ok;
  logic drl_cond;
  blsl_tmr u_drl_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .tick(tick),
    .start(eng_eff && !eng_prev),
    .cancel(!eng_eff),
    .load(`BLSL_DRL_TICKS),
    .busy(),
    .done(drl_done),
    .remain()
  );
  assign drl_cond = drl_mode == blsl_pkg::BLSL_DRL_NO_MAIN ? !main_on
    : drl_mode == blsl_pkg::BLSL_DRL_NO_BEAM_PARK
      ? !main_on && !dip_on && gear != blsl_pkg::BLSL_GEAR_P : 1'b0;

  // Fog lamps: a latched state, blanked at the relay while suspended
  logic rf_on;
  logic ff_susp;
  logic ff_press;
  logic rf_press;
  logic ff_drop;
  logic rf_drop;
  assign ff_susp = crank
    || (ff_mode == blsl_pkg::BLSL_FOG_OFF_MAIN && main_on);
  assign ff_press = ff_btn && !ff_btn_prev && !ff_susp && ign_on && lights;
  assign rf_press = rf_btn && !rf_btn_prev && !crank && ign_on && lights;
  assign ff_drop = !lights || !ign_on || link_fail
    || ff_mode == blsl_pkg::BLSL_FOG_NONE;
  // A front fog lost to link failure must not take the rear fog with it
  assign rf_drop = !lights || !ign_on
    || (ff_prev && !ff_on && !link_fail && ff_mode != blsl_pkg::BLSL_FOG_NONE);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ff_on <= 1'b0;
      rf_on <= 1'b0;
    end
    else if (ce)
    begin
      if (ff_drop)
        ff_on <= 1'b0;
      else if (ff_press)
        ff_on <= !ff_on;
      if (rf_drop)
        rf_on <= 1'b0;
      else if (rf_press)
        rf_on <= !rf_on;
    end
  end

  // Courtesy lamps
  logic fade_busy;
  logic [19:0] fade_rem;
  logic all_shut;
  logic open_ev;
  logic close_ev;
  logic unlock_ev;
  logic ignoff_ev;
  logic hold_trig;
  logic [19:0] hold_load;
  logic [7:0] pwm_cnt;
  assign all_shut = doors == 4'h0;
  assign open_ev = |(doors & ~doors_prev);
  assign close_ev = |(~doors & doors_prev) && all_shut && !crank;
  assign unlock_ev = (remote_unlock || drv_unlock) && all_shut && !crank;
  assign ignoff_ev = ign_prev[1] && ign_pos == blsl_pkg::BLSL_IGN_OFF && all_shut;
  assign hold_trig = open_ev || close_ev || unlock_ev || ignoff_ev;
  assign hold_load = transit ? `BLSL_CLOSE_TICKS
    : open_ev ? `BLSL_DOOR_TICKS
    : (unlock_ev || ignoff_ev) ? `BLSL_UNLOCK_TICKS
    : `BLSL_CLOSE_TICKS;
  blsl_tmr u_hold_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .tick(tick),
    .start(hold_trig),
    .cancel(crank || lock_cmd),
    .load(hold_load),
    .busy(hold_busy),
    .done(),
    .remain()
  );
  blsl_tmr u_fade_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .tick(tick),
    .start(hold_prev && !hold_busy),
    .cancel(hold_busy),
    .load(`BLSL_FADE_TICKS),
    .busy(fade_busy),
    .done(),
    .remain(fade_rem)
  );

  // Odometer plausibility
  logic [20:0] odo_clamp;
  logic [20:0] odo_last;
  logic [3:0] same_cnt;
  logic odo_take;
  logic odo_same;
  logic odo_cmp;
  logic [20:0] odo_gap;
  assign odo_clamp = odo_rx > `BLSL_ODO_MAX ? `BLSL_ODO_MAX : odo_rx;
  assign odo_take = odo_rx_valid && ign_on && !link_fail;
  assign odo_same = odo_clamp == odo_last;
  assign odo_cmp = odo_take && odo_same && same_cnt >= `BLSL_SAME_LAST;
  assign odo_gap = absdiff(odo_clamp, odo_store);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      odo_last <= `BLSL_ODO_RESET;
      same_cnt <= 4'h0;
      odo_store <= `BLSL_ODO_RESET;
      odo_flash <= 1'b0;
      ctrl <= `BLSL_CTRL_RESET;
    end
    else if (ce)
    begin
      if (odo_take)
      begin
        odo_last <= odo_clamp;
        same_cnt <= !odo_same ? 4'h0 : same_cnt == 4'hF ? same_cnt : same_cnt + 4'h1;
      end
      // A catch-up from the link wins over a software write in the same cycle
      if (odo_cmp && odo_store <= odo_clamp && odo_gap <= `BLSL_ODO_TOL)
        odo_store <= odo_clamp;
      else if (wr_go && aw_addr == `BLSL_REG_ODO)
        odo_store <= next_odo_sw;
      if (!ign_on)
        odo_flash <= 1'b0;
      else if (odo_cmp)
        odo_flash <= ctrl[`BLSL_CTRL_WARN] && odo_gap >= `BLSL_ODO_TOL;
      if (wr_go && aw_addr == `BLSL_REG_CTRL)
        ctrl <= next_ctrl;
    end
  end

  // Registered relay outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eng_ok <= 1'b0;
      drl_rly <= 1'b0;
      ff_rly <= 1'b0;
      rf_rly <= 1'b0;
      courtesy_lamp <= 1'b0;
      starter_rly <= 1'b0;
      nrpb_out <= 1'b0;
      pwm_cnt <= 8'h00;
    end
    else if (ce)
    begin
      eng_ok <= eng_eff && (eng_ok || drl_done);
      drl_rly <= eng_ok && drl_cond;
      ff_rly <= ff_on && !ff_susp && !ff_drop;
      rf_rly <= rf_on && !crank && !rf_drop;
      pwm_cnt <= pwm_cnt + 8'h01;
      courtesy_lamp <= hold_busy || (fade_busy && pwm_cnt < fade_rem[10:3]);
      starter_rly <= crank && immob_ok && !eng_eff;
      nrpb_out <= ign_on && (brake || (auto_gbox && (gear == blsl_pkg::BLSL_GEAR_N
        || gear == blsl_pkg::BLSL_GEAR_P || gear == blsl_pkg::BLSL_GEAR_R)));
    end
  end

  assign status = {22'h000000, odo_flash, nrpb_out, starter_rly, courtesy_lamp, rf_rly,
    ff_rly, drl_rly, eng_ok, link_fail, hold_busy};

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  property p_drl_qual;
    $rose(eng_ok) |-> $past(eng_eff, 1) && $past(eng_eff, 2);
  endproperty
  a_drl_qual: assert property (p_drl_qual) else $error("Daylight qualified early");

  property p_drl_eng;
    drl_rly |-> $past(eng_ok) && $past(drl_mode) != blsl_pkg::BLSL_DRL_NONE;
  endproperty
  a_drl_eng: assert property (p_drl_eng) else $error("Daylight relay without engine");

  property p_ff_lights;
    ff_rly |-> $past(lights) && $past(ign_on) && !$past(crank);
  endproperty
  a_ff_lights: assert property (p_ff_lights) else $error("Front fog on illegally");

  property p_rf_follow;
    $fell(ff_on) && !link_fail && ff_mode != blsl_pkg::BLSL_FOG_NONE |=> !rf_on;
  endproperty
  a_rf_follow: assert property (p_rf_follow) else $error("Rear fog kept after front");

  property p_ff_link;
    link_fail |=> !ff_on ##1 !ff_rly;
  endproperty
  a_ff_link: assert property (p_ff_link) else $error("Front fog held on link fail");

  property p_rf_crank;
    crank |=> !rf_rly;
  endproperty
  a_rf_crank: assert property (p_rf_crank) else $error("Rear fog on during crank");

  property p_transit;
    hold_trig && transit |-> hold_load == `BLSL_CLOSE_TICKS;
  endproperty
  a_transit: assert property (p_transit) else $error("Transit hold length wrong");

  property p_odo_clamp;
    odo_last <= `BLSL_ODO_MAX && odo_store <= `BLSL_ODO_MAX;
  endproperty
  a_odo_clamp: assert property (p_odo_clamp) else $error("Odometer above maximum");

  property p_starter;
    starter_rly |-> $past(crank) && $past(immob_ok) && !$past(eng_eff);
  endproperty
  a_starter: assert property (p_starter) else $error("Starter enabled illegally");

  property p_cruise;
    ign_on && brake |=> nrpb_out;
  endproperty
  a_cruise: assert property (p_cruise) else $error("Cruise inhibit missing");
endmodule

// *** bench/blsl_ipack_model.sv ***
`timescale 1ns/1ps
module blsl_ipack_model (
  // Clock
  input wire logic aclk,
  // Link to the body controller
  output logic eng_run,
  output logic link_fail,
  output logic [20:0] odo_rx,
  output logic odo_rx_valid
);
  initial
  begin
    eng_run = 1'b0;
    link_fail = 1'b0;
    odo_rx = 21'h000000;
    odo_rx_valid = 1'b0;
  end
  task automatic set_link(input logic run, input logic fail);
    @(posedge aclk);
    eng_run <= run;
    link_fail <= fail;
  endtask
  // Reading is inverted between strobes so a stale value never looks valid
  task automatic send(input logic [20:0] v, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      odo_rx <= v;
      odo_rx_valid <= 1'b1;
      @(posedge aclk);
      odo_rx <= ~v;
      odo_rx_valid <= 1'b0;
    end
  endtask
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  localparam logic [1:0] OFF = blsl_pkg::BLSL_IGN_OFF;
  localparam logic [1:0] AUX = blsl_pkg::BLSL_IGN_AUX;
  localparam logic [1:0] RUN = blsl_pkg::BLSL_IGN_RUN;
  localparam logic [1:0] CRK = blsl_pkg::BLSL_IGN_CRANK;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, eng_run, link_fail, odo_v;
  logic side_on, dip_on, main_on, ff_btn, rf_btn, immob_ok, brake, r_unl, d_unl, lock;
  logic drl, ff, rf, ctsy, strt, nrpb, flash;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, ign;
  logic [2:0] gear;
  logic [3:0] doors;
  logic [20:0] odo;
  int n_errors = 0;
  int checks = 0;
  blsl_ipack_model m (.aclk(aclk), .eng_run(eng_run), .link_fail(link_fail), .odo_rx(odo),
    .odo_rx_valid(odo_v));
  blsl_top #(.TICK_CYCLES(1)) uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ign_pos(ign), .side_on(side_on), .dip_on(dip_on), .main_on(main_on), .ff_btn(ff_btn),
    .rf_btn(rf_btn), .eng_run(eng_run), .link_fail(link_fail), .immob_ok(immob_ok),
    .brake(brake), .gear(gear), .doors(doors), .remote_unlock(r_unl), .drv_unlock(d_unl),
    .lock_cmd(lock), .odo_rx(odo), .odo_rx_valid(odo_v), .drl_rly(drl), .ff_rly(ff),
    .rf_rly(rf), .courtesy_lamp(ctsy), .starter_rly(strt), .nrpb_out(nrpb),
    .odo_flash(flash));
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic report_and_stop();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk(32'(got), 32'(exp));
  endtask
  // Outputs are judged at the falling edge, well away from the update edge
  task automatic wt(input int n);
    repeat (n) @(negedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    logic [1:0] r;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    r = 2'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok)
    begin
      @(negedge aclk);
      aw_ok = aw_ok | awready;
      w_ok = w_ok | wready;
      b_ok = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ar_ok, r_ok;
    logic [1:0] r;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok)
    begin
      @(negedge aclk);
      ar_ok = ar_ok | arready;
      r_ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask
  task automatic vs(input logic [1:0] i, input int s, dp, mn, bk, input logic [2:0] g);
    @(posedge aclk);
    ign <= i;
    side_on <= s != 0;
    dip_on <= dp != 0;
    main_on <= mn != 0;
    brake <= bk != 0;
    gear <= g;
    wt(3);
  endtask
  task automatic btn(input int f, input int r);
    @(posedge aclk);
    ff_btn <= f != 0;
    rf_btn <= r != 0;
    @(posedge aclk);
    ff_btn <= 1'b0;
    rf_btn <= 1'b0;
    wt(4);
  endtask
  task automatic ev(input logic [2:0] e);
    @(posedge aclk);
    {r_unl, d_unl, lock} <= e;
    @(posedge aclk);
    {r_unl, d_unl, lock} <= 3'h0;
  endtask
  task automatic t_regs();
    rd(8'h00, 2'h0, v);
    chk(v, 32'h00000000);
    rd(8'h08, 2'h0, v);
    chk(v, 32'h00000000);
    rd(8'h0C, 2'h2, v);
    wr(8'h04, 32'h00000001, 2'h2);
    wr(8'h0C, 32'h00000001, 2'h2);
    wr(8'h00, 32'h0000005A, 2'h0);
    rd(8'h00, 2'h0, v);
    chk(v, 32'h0000005A);
    wr(8'h00, 32'h00000000, 2'h0);
  endtask
  task automatic t_cruise();
    vs(RUN, 0, 0, 0, 1, 3'h3);
    chk1(nrpb, 1'b1);
    vs(RUN, 0, 0, 0, 0, 3'h0);
    chk1(nrpb, 1'b0);
    vs(OFF, 0, 0, 0, 1, 3'h3);
    chk1(nrpb, 1'b0);
    wr(8'h00, 32'h00000020, 2'h0);
    for (int g = 0; g < 4; g++)
    begin
      vs(RUN, 0, 0, 0, 0, 3'(g));
      chk1(nrpb, g != 3);
    end
  endtask
  task automatic t_start();
    vs(CRK, 0, 0, 0, 0, 3'h3);
    @(posedge aclk);
    immob_ok <= 1'b1;
    wt(3);
    chk1(strt, 1'b1);
    m.set_link(1'b1, 1'b0);
    wt(3);
    chk1(strt, 1'b0);
    m.set_link(1'b1, 1'b1);
    wt(3);
    chk1(strt, 1'b1);
    @(posedge aclk);
    immob_ok <= 1'b0;
    wt(3);
    chk1(strt, 1'b0);
    m.set_link(1'b0, 1'b0);
  endtask
  task automatic t_drl();
    wr(8'h00, 32'h00000001, 2'h0);
    vs(RUN, 0, 0, 0, 0, 3'h3);
    m.set_link(1'b1, 1'b0);
    wt(1990);
    chk1(drl, 1'b0);
    wt(40);
    chk1(drl, 1'b1);
    vs(RUN, 0, 0, 1, 0, 3'h3);
    chk1(drl, 1'b0);
    wr(8'h00, 32'h00000002, 2'h0);
    vs(RUN, 0, 0, 0, 0, 3'h0);
    chk1(drl, 1'b0);
    vs(RUN, 0, 0, 0, 0, 3'h3);
    chk1(drl, 1'b1);
    vs(RUN, 0, 1, 0, 0, 3'h3);
    chk1(drl, 1'b0);
    m.set_link(1'b0, 1'b0);
  endtask
  task automatic t_fog();
    wr(8'h00, 32'h00000004, 2'h0);
    vs(RUN, 1, 0, 0, 0, 3'h3);
    btn(1, 0);
    btn(0, 1);
    chk(32'({ff, rf}), 32'h00000003);
    vs(CRK, 1, 0, 0, 0, 3'h3);
    chk(32'({ff, rf}), 32'h00000000);
    btn(1, 1);
    vs(RUN, 1, 0, 0, 0, 3'h3);
    chk(32'({ff, rf}), 32'h00000003);
    btn(1, 0);
    chk(32'({ff, rf}), 32'h00000000);
    btn(1, 0);
    btn(0, 1);
    m.set_link(1'b0, 1'b1);
    wt(3);
    chk(32'({ff, rf}), 32'h00000001);
    vs(RUN, 0, 0, 0, 0, 3'h3);
    chk1(rf, 1'b0);
    m.set_link(1'b0, 1'b0);
    vs(RUN, 1, 0, 0, 0, 3'h3);
    chk(32'({ff, rf}), 32'h00000000);
    wr(8'h00, 32'h00000008, 2'h0);
    btn(1, 0);
    vs(RUN, 1, 0, 1, 0, 3'h3);
    chk1(ff, 1'b0);
    btn(1, 0);
    vs(RUN, 1, 0, 0, 0, 3'h3);
    chk1(ff, 1'b1);
    vs(OFF, 1, 0, 0, 0, 3'h3);
    chk1(ff, 1'b0);
    wr(8'h00, 32'h00000000, 2'h0);
    vs(RUN, 1, 0, 0, 0, 3'h3);
    btn(1, 0);
    chk1(ff, 1'b0);
  endtask
  task automatic t_ctsy();
    int lit;
    lit = 0;
    vs(OFF, 0, 0, 0, 0, 3'h3);
    @(posedge aclk);
    doors <= 4'h1;
    wt(3);
    chk1(ctsy, 1'b1);
    @(posedge aclk);
    doors <= 4'h0;
    wt(14900);
    chk1(ctsy, 1'b1);
    // Dimming shows as a duty between always lit and dark
    repeat (2200)
    begin
      wt(1);
      lit += int'(ctsy === 1'b1);
    end
    chk1(lit > 150 && lit < 2050, 1'b1);
    chk1(ctsy, 1'b0);
    @(posedge aclk);
    doors <= 4'h2;
    wt(3);
    @(posedge aclk);
    doors <= 4'h0;
    wt(100);
    ev(3'b001);
    wt(2100);
    chk1(ctsy, 1'b0);
    wr(8'h00, 32'h00000040, 2'h0);
    ev(3'b110);
    wt(14900);
    chk1(ctsy, 1'b1);
    wt(2300);
    chk1(ctsy, 1'b0);
  endtask
  task automatic t_odo();
    vs(RUN, 0, 0, 0, 0, 3'h3);
    wr(8'h00, 32'h00000010, 2'h0);
    wr(8'h08, 32'h00000064, 2'h0);
    m.send(21'h000069, 15);
    wt(3);
    rd(8'h08, 2'h0, v);
    chk(v, 32'h00000064);
    m.send(21'h000069, 1);
    wt(3);
    rd(8'h08, 2'h0, v);
    chk(v, 32'h00000069);
    chk1(flash, 1'b0);
    m.send(21'h0000C8, 16);
    wt(3);
    chk1(flash, 1'b1);
    rd(8'h08, 2'h0, v);
    chk(v, 32'h00000069);
    vs(AUX, 0, 0, 0, 0, 3'h3);
    m.send(21'h00006B, 16);
    wt(3);
    rd(8'h08, 2'h0, v);
    chk(v, 32'h00000069);
    vs(RUN, 0, 0, 0, 0, 3'h3);
    wr(8'h08, 32'h00188D22, 2'h0);
    m.send(21'h1FFFFF, 16);
    wt(3);
    rd(8'h08, 2'h0, v);
    chk(v, 32'h00188D27);
  endtask
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    {side_on, dip_on, main_on, ff_btn, rf_btn, immob_ok, brake} = 7'h00;
    {r_unl, d_unl, lock} = 3'h0;
    ign = OFF;
    gear = 3'h3;
    doors = 4'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_cruise();
    t_start();
    t_drl();
    t_fog();
    t_ctsy();
    t_odo();
    report_and_stop();
  end
endmodule
